// [hw/iwc_interrupt_wake.v]
// How it works
// - Vector fetch address points at a byte pair holding a 16-bit start address.
// - Request n vectors through locations 2n and 2n+1, requests 0 to 5.
// - Request 1 on falling line 3; requests 0 and 2 programmable; timer input feeds 2.
// - Request register bits 7:6 select edges for line 1 and line 2.
// - Among pending unmasked requests, priority register ordering picks the grant.
// - Grant starts interrupt cycle: disable further interrupts, save state, jump to vector.
// - Masked requests still latch so software can poll the request register.
// - Request 3 from software only, or serial byte received when serial enabled.
// - Request 4 from timer zero on large variant else software; request 5 timer one.
// - Comparator one feeds request 2, comparator two feeds request 0, same edges.
// - Control bits 4:2 pick wake source: 0/1 power-on only, 2-4 upper lines.
// - Code 5 port-2 line 7, 6 NOR of lines 0-3, 7 NOR of 0-7.
// - Upper lines in analog comparator mode cannot wake the device.
// - Serial compare match wakes whenever enabled, besides the selected source.
// - Control bit 5 set gives 5 ms delay after wake; clear is fast wake.
// - Control bit 6 chooses wake level high or low; cleared at power-on.
// - Read-only bit 7 set on entering sleep, cleared by power-on or watchdog reset.
`timescale 1ns/1ps
`default_nettype none
`include "iwc_defines.vh"
module iwc_interrupt_wake #(
	parameter DELAY_CYC = `IWC_DELAY_CYC,
	parameter LARGE_VARIANT = 1
) (
	input wire mclk_i,
	input wire rst_i,
	input wire reg_wr_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	output reg [7:0] reg_rdata_o,
	input wire upper_port_line1_i,
	input wire upper_port_line2_i,
	input wire upper_port_line3_i,
	input wire [7:0] port_two_i,
	input wire comparator_one_irq_i,
	input wire comparator_two_irq_i,
	input wire analog_mode_i,
	input wire timer_in_sel_i,
	input wire timer_in_edge_i,
	input wire timer_zero_i,
	input wire timer_one_i,
	input wire serial_enable_i,
	input wire serial_byte_done_i,
	input wire serial_compare_enable_i,
	input wire serial_compare_match_i,
	input wire int_enable_i,
	input wire cycle_ack_i,
	input wire enter_sleep_i,
	output reg int_cycle_o,
	output reg [2:0] int_grant_o,
	output reg [3:0] vector_addr_o,
	output reg int_disable_o,
	output reg save_state_o,
	output reg wake_o,
	output reg wake_reset_o,
	output reg sleeping_o
);
	////////////////////////////////////////////////////////////////////
	wire l1_lvl, l1_rise, l1_fall;
	wire l2_lvl, l2_rise, l2_fall;
	wire l3_lvl, l3_fall;
	wire p7_lvl;
	iwc_edge_sync u_l1 (.mclk_i(mclk_i), .rst_i(rst_i), .pin_i(upper_port_line1_i),
		.level_o(l1_lvl), .rise_o(l1_rise), .fall_o(l1_fall));
	iwc_edge_sync u_l2 (.mclk_i(mclk_i), .rst_i(rst_i), .pin_i(upper_port_line2_i),
		.level_o(l2_lvl), .rise_o(l2_rise), .fall_o(l2_fall));
	iwc_edge_sync u_l3 (.mclk_i(mclk_i), .rst_i(rst_i), .pin_i(upper_port_line3_i),
		.level_o(l3_lvl), .rise_o(), .fall_o(l3_fall));
	iwc_edge_sync u_p7 (.mclk_i(mclk_i), .rst_i(rst_i), .pin_i(port_two_i[7]),
		.level_o(p7_lvl), .rise_o(), .fall_o());
	// Port 2 low nibble and high lines only feed level NOR, one shared sync
	reg [7:0] p2_s1, p2_s2, p2_s3, p2_lvl;
	always @(posedge mclk_i) begin
		if (rst_i) begin
			p2_s1 <= 8'hff;
			p2_s2 <= 8'hff;
			p2_s3 <= 8'hff;
			p2_lvl <= 8'hff;
		end else begin
			p2_s1 <= port_two_i;
			p2_s2 <= p2_s1;
			p2_s3 <= p2_s2;
			if (p2_s2 == p2_s3)
				p2_lvl <= p2_s3;
		end
	end

	////////////////////////////////////////////////////////////////////
	reg [7:0] req_reg;
	reg [7:0] prio_reg;
	reg [7:0] mask_reg;
	reg [7:0] stop_recovery_control;
	wire [1:0] edge_sel = req_reg[`IWC_EDGE_HI:`IWC_EDGE_LO];
	// Line 1 edge for request 2, line 2 edge for request 0
	reg sel_l1;
	reg sel_l2;
	always @* begin
		case (edge_sel)
		2'h0: begin
			sel_l1 = l1_fall;
			sel_l2 = l2_fall;
		end
		2'h1: begin
			sel_l1 = l1_fall;
			sel_l2 = l2_rise;
		end
		2'h2: begin
			sel_l1 = l1_rise;
			sel_l2 = l2_fall;
		end
		default: begin
			sel_l1 = l1_rise | l1_fall;
			sel_l2 = l2_rise | l2_fall;
		end
		endcase
	end
	// Comparators share the pin edge select, as pins are their inputs
	wire src0 = analog_mode_i ? (comparator_two_irq_i & sel_l2) : sel_l2;
	wire src2_pin = analog_mode_i ? (comparator_one_irq_i & sel_l1) : sel_l1;
	wire src2 = timer_in_sel_i ? timer_in_edge_i : src2_pin;
	wire src1 = l3_fall;
	wire src3 = serial_enable_i & serial_byte_done_i;
	wire src4 = (LARGE_VARIANT != 0) & timer_zero_i;
	wire src5 = timer_one_i;
	wire [5:0] hw_evt = {src5, src4, src3, src2, src1, src0};

	wire wr_req = reg_wr_i && (reg_addr_i == `IWC_ADDR_REQ);
	wire wr_smr = reg_wr_i && (reg_addr_i == `IWC_ADDR_SMR);

	////////////////////////////////////////////////////////////////////
	// Priority: prio_reg[2:0] rotates the fixed order; hazard-free single pick
	wire [5:0] pend = req_reg[5:0] & mask_reg[5:0];
	reg [2:0] pick;
	reg found;
	integer i;
	reg [2:0] idx;
	reg [3:0] rot;
	always @* begin
		pick = 3'h0;
		found = 1'b0;
		idx = 3'h0;
		rot = 4'h0;
		for (i = 5; i >= 0; i = i - 1) begin
			// Four bits, as index plus offset can pass seven
			rot = {1'b0, i[2:0]} + {1'b0, prio_reg[2:0]};
			if (rot >= 4'h6)
				rot = rot - 4'h6;
			idx = rot[2:0];
			if (prio_reg[2:0] < 3'd6 && pend[idx]) begin
				pick = idx;
				found = 1'b1;
			end else if (prio_reg[2:0] >= 3'd6 && pend[i]) begin
				pick = i[2:0];
				found = 1'b1;
			end
		end
	end

	localparam ST_IDLE = 3'b001;
	localparam ST_CYCLE = 3'b010;
	localparam ST_DONE = 3'b100;
	reg [2:0] state;
	wire grant = (state == ST_IDLE) && found && int_enable_i;

	always @(posedge mclk_i) begin
		if (rst_i) begin
			req_reg <= 8'h00;
		end else begin
			// Hardware set wins over a write or grant clearing the same bit
			req_reg[7:6] <= wr_req ? reg_wdata_i[7:6] : req_reg[7:6];
			req_reg[5:0] <= (wr_req ? reg_wdata_i[5:0] :
				(req_reg[5:0] & ~(grant ? (6'h01 << pick) : 6'h00))) | hw_evt;
		end
	end

	always @(posedge mclk_i) begin
		if (rst_i) begin
			prio_reg <= 8'h00;
			mask_reg <= 8'h00;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `IWC_ADDR_PRIO)
				prio_reg <= reg_wdata_i;
			if (reg_addr_i == `IWC_ADDR_MASK)
				mask_reg <= reg_wdata_i;
		end
	end

	always @(posedge mclk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			int_cycle_o <= 1'b0;
			int_grant_o <= 3'h0;
			vector_addr_o <= 4'h0;
			int_disable_o <= 1'b0;
			save_state_o <= 1'b0;
		end else begin
			save_state_o <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (grant) begin
					state <= ST_CYCLE;
					int_cycle_o <= 1'b1;
					int_disable_o <= 1'b1;
					save_state_o <= 1'b1;
					int_grant_o <= pick;
					// Vector pair base; core reads this byte and the next
					vector_addr_o <= pick[2:0] * `IWC_VEC_STEP;
				end
			end
			ST_CYCLE: begin
				if (cycle_ack_i) begin
					state <= ST_DONE;
					int_cycle_o <= 1'b0;
				end
			end
			ST_DONE: begin
				// Core re-enables by raising int_enable_i after its return
				int_disable_o <= 1'b0;
				state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	wire [2:0] src_code = stop_recovery_control[`IWC_SRC_HI:`IWC_SRC_LO];
	wire lvl_hi = stop_recovery_control[`IWC_SMR_LEVEL];
	reg src_lvl;
	always @* begin
		case (src_code)
		`IWC_SRC_L1: src_lvl = analog_mode_i ? ~lvl_hi : l1_lvl;
		`IWC_SRC_L2: src_lvl = analog_mode_i ? ~lvl_hi : l2_lvl;
		`IWC_SRC_L3: src_lvl = analog_mode_i ? ~lvl_hi : l3_lvl;
		`IWC_SRC_P27: src_lvl = p7_lvl;
		`IWC_SRC_NOR4: src_lvl = ~(|p2_lvl[3:0]);
		`IWC_SRC_NOR8: src_lvl = ~(|p2_lvl);
		default: src_lvl = ~lvl_hi;
		endcase
	end
	wire src_wake = (src_lvl == lvl_hi);
	wire cmp_wake = serial_enable_i & serial_compare_enable_i & serial_compare_match_i;

	// Fast mode: level must persist this many cycles to count
	reg [2:0] fast_cnt;
	reg [22:0] dly_cnt;
	reg delaying;
	always @(posedge mclk_i) begin
		if (rst_i) begin
			stop_recovery_control <= `IWC_SMR_RESET;
			sleeping_o <= 1'b0;
			wake_o <= 1'b0;
			wake_reset_o <= 1'b0;
			fast_cnt <= 3'h0;
			dly_cnt <= 23'h0;
			delaying <= 1'b0;
		end else begin
			wake_o <= 1'b0;
			if (wr_smr)
				stop_recovery_control[6:0] <= reg_wdata_i[6:0];
			if (enter_sleep_i && !sleeping_o) begin
				sleeping_o <= 1'b1;
				stop_recovery_control[`IWC_SMR_WARM] <= 1'b1;
				fast_cnt <= 3'h0;
			end else if (sleeping_o) begin
				fast_cnt <= src_wake ? ((fast_cnt == 3'h7) ? fast_cnt : fast_cnt + 3'h1) : 3'h0;
				if (cmp_wake || (src_wake && (stop_recovery_control[`IWC_SMR_DELAY] ||
					fast_cnt >= (`IWC_FAST_CYC - 1)))) begin
					sleeping_o <= 1'b0;
					if (stop_recovery_control[`IWC_SMR_DELAY]) begin
						delaying <= 1'b1;
						wake_reset_o <= 1'b1;
						dly_cnt <= DELAY_CYC[22:0];
					end else begin
						wake_o <= 1'b1;
					end
				end
			end else if (delaying) begin
				if (dly_cnt == 23'h1) begin
					delaying <= 1'b0;
					wake_reset_o <= 1'b0;
					wake_o <= 1'b1;
				end
				dly_cnt <= dly_cnt - 23'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	always @(posedge mclk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			case (reg_addr_i)
			`IWC_ADDR_REQ: reg_rdata_o <= req_reg;
			`IWC_ADDR_SMR: reg_rdata_o <= stop_recovery_control;
			`IWC_ADDR_MASK: reg_rdata_o <= mask_reg;
			default: reg_rdata_o <= 8'h00;
			endcase
		end
	end
endmodule // iwc_interrupt_wake
`default_nettype wire

// [hw/iwc_defines.vh]
`ifndef IWC_DEFINES_VH
`define IWC_DEFINES_VH
// Register addresses in the core's register file
`define IWC_ADDR_REQ 8'hfa
`define IWC_ADDR_PRIO 8'hf9
`define IWC_ADDR_MASK 8'hfb
`define IWC_ADDR_SMR 8'h0b
// Request register fields
`define IWC_EDGE_HI 7
`define IWC_EDGE_LO 6
`define IWC_NREQ 6
// Stop-recovery control fields
`define IWC_SMR_WARM 7
`define IWC_SMR_LEVEL 6
`define IWC_SMR_DELAY 5
`define IWC_SRC_HI 4
`define IWC_SRC_LO 2
`define IWC_SMR_RESET 8'h20
// Wake source codes
`define IWC_SRC_L1 3'h2
`define IWC_SRC_L2 3'h3
`define IWC_SRC_L3 3'h4
`define IWC_SRC_P27 3'h5
`define IWC_SRC_NOR4 3'h6
`define IWC_SRC_NOR8 3'h7
// Timing
`define IWC_CLK_NS 10
`define IWC_DELAY_US 5000
`define IWC_DELAY_CYC ((`IWC_DELAY_US * 1000) / `IWC_CLK_NS)
`define IWC_FAST_CYC 5
`define IWC_VEC_STEP 4'h2
`endif

// [hw/iwc_edge_sync.v]
`timescale 1ns/1ps
`default_nettype none
module iwc_edge_sync (
	input wire mclk_i,
	input wire rst_i,
	input wire pin_i,
	output reg level_o,
	output wire rise_o,
	output wire fall_o
);
	reg s1;
	reg s2;
	reg s3;
	always @(posedge mclk_i) begin
		if (rst_i) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			level_o <= 1'b1;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
			// Change counts only once the two later stages agree
			if (s2 == s3)
				level_o <= s3;
		end
	end
	assign rise_o = (s2 == s3) && s3 && !level_o;
	assign fall_o = (s2 == s3) && !s3 && level_o;
endmodule // iwc_edge_sync
`default_nettype wire

// [tb/iwc_interrupt_wake_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module iwc_interrupt_wake_asserts #(
	parameter DELAY_CYC = 20
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic int_enable_i,
	input wire logic cycle_ack_i,
	input wire logic int_cycle_o,
	input wire logic [2:0] int_grant_o,
	input wire logic [3:0] vector_addr_o,
	input wire logic int_disable_o,
	input wire logic save_state_o,
	input wire logic wake_o,
	input wire logic wake_reset_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// Cycles the wake reset has stood so far
	int dly_len;
	always_ff @(posedge mclk_i)
		dly_len <= (rst_i || !wake_reset_o) ? 0 : dly_len + 1;
	a_vector_pair: assert property (int_cycle_o |-> vector_addr_o == {int_grant_o, 1'b0})
		else $error("vector not twice grant");
	a_grant_range: assert property (int_cycle_o |-> int_grant_o < 3'h6)
		else $error("grant out of range");
	a_grant_enabled: assert property ($rose(int_cycle_o) |-> $past(int_enable_i))
		else $error("grant while disabled");
	a_save_at_grant: assert property ($rose(int_cycle_o) |-> save_state_o && int_disable_o)
		else $error("no save at grant");
	a_save_single: assert property (save_state_o |=> !save_state_o)
		else $error("save pulse too long");
	a_cycle_held: assert property (int_cycle_o && !cycle_ack_i |=> int_cycle_o)
		else $error("cycle dropped early");
	a_cycle_ends: assert property (int_cycle_o && cycle_ack_i |=> !int_cycle_o)
		else $error("cycle not ended");
	a_delay_span: assert property ($rose(wake_reset_o) |-> wake_reset_o [*8])
		else $error("wake delay too short");
	a_wake_single: assert property (wake_o |=> !wake_o)
		else $error("wake pulse too long");
	a_delay_length: assert property ($fell(wake_reset_o) |-> dly_len == DELAY_CYC)
		else $error("wake delay length wrong");
endmodule // iwc_interrupt_wake_asserts
bind iwc_interrupt_wake iwc_interrupt_wake_asserts #(.DELAY_CYC(DELAY_CYC)) u_chk (
	.mclk_i(mclk_i), .rst_i(rst_i), .int_enable_i(int_enable_i), .cycle_ack_i(cycle_ack_i),
	.int_cycle_o(int_cycle_o), .int_grant_o(int_grant_o), .vector_addr_o(vector_addr_o),
	.int_disable_o(int_disable_o), .save_state_o(save_state_o), .wake_o(wake_o),
	.wake_reset_o(wake_reset_o));
`default_nettype wire

// [tb/iwc_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module iwc_core_model (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic int_cycle_i,
	input wire logic slow_i,
	output logic cycle_ack_o
);
	logic [3:0] wait_cnt;
	// Slow mode stretches the cycle so holding is seen
	always_ff @(posedge mclk_i) begin
		if (rst_i || !int_cycle_i) begin
			wait_cnt <= 4'h0;
			cycle_ack_o <= 1'b0;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
			cycle_ack_o <= wait_cnt == (slow_i ? 4'h6 : 4'h1);
		end
	end
endmodule // iwc_core_model
`default_nettype wire

// [tb/iwc_interrupt_wake_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iwc_defines.vh"
module iwc_interrupt_wake_tb;
	logic mclk_i, rst_i, reg_wr_i, int_enable_i, cycle_ack_i, enter_sleep_i, slow, seen, sr;
	logic upper_port_line1_i, upper_port_line2_i, upper_port_line3_i, analog_mode_i;
	logic comparator_one_irq_i, comparator_two_irq_i, timer_in_sel_i, timer_in_edge_i;
	logic timer_zero_i, timer_one_i, serial_enable_i, serial_byte_done_i;
	logic serial_compare_enable_i, serial_compare_match_i, int_cycle_o, int_disable_o;
	logic save_state_o, wake_o, wake_reset_o, sleeping_o;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, port_two_i;
	logic [2:0] int_grant_o, k;
	logic [3:0] vector_addr_o;
	int failures, compares, i, e;
	iwc_interrupt_wake #(.DELAY_CYC(20)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i),
		.reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .upper_port_line1_i(upper_port_line1_i),
		.upper_port_line2_i(upper_port_line2_i), .upper_port_line3_i(upper_port_line3_i),
		.port_two_i(port_two_i), .comparator_one_irq_i(comparator_one_irq_i),
		.comparator_two_irq_i(comparator_two_irq_i), .analog_mode_i(analog_mode_i),
		.timer_in_sel_i(timer_in_sel_i), .timer_in_edge_i(timer_in_edge_i),
		.timer_zero_i(timer_zero_i), .timer_one_i(timer_one_i),
		.serial_enable_i(serial_enable_i), .serial_byte_done_i(serial_byte_done_i),
		.serial_compare_enable_i(serial_compare_enable_i),
		.serial_compare_match_i(serial_compare_match_i), .int_enable_i(int_enable_i),
		.cycle_ack_i(cycle_ack_i), .enter_sleep_i(enter_sleep_i), .int_cycle_o(int_cycle_o),
		.int_grant_o(int_grant_o), .vector_addr_o(vector_addr_o),
		.int_disable_o(int_disable_o), .save_state_o(save_state_o), .wake_o(wake_o),
		.wake_reset_o(wake_reset_o), .sleeping_o(sleeping_o));
	iwc_core_model u_core (.mclk_i(mclk_i), .rst_i(rst_i), .int_cycle_i(int_cycle_o),
		.slow_i(slow), .cycle_ack_o(cycle_ack_i));
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h want %h", $time, got, exp);
			failures++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr_i = a;
		reg_wdata_i = v;
		reg_wr_i = 1'b1;
		tick(1);
		reg_wr_i = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr_i = a;
		tick(1);
		chk(reg_rdata_o, exp);
	endtask
	task automatic rst_dut();
		rst_i = 1'b1;
		tick(2);
		rst_i = 1'b0;
	endtask
	function automatic logic [2:0] pri(input logic [2:0] k, input int i);
		int b = (k > 3'h5) ? 0 : int'(k);
		return 3'((b + i) % 6);
	endfunction
	task automatic grant(input logic [2:0] want);
		for (int n = 0; n < 40 && int_cycle_o !== 1'b1; n++) tick(1);
		chk(int_cycle_o, 1'b1);
		chk(int_grant_o, want);
		chk(vector_addr_o, {want, 1'b0});
		for (int n = 0; n < 40 && int_cycle_o !== 1'b0; n++) tick(1);
		tick(3);
	endtask
	task automatic wk(input logic [7:0] stop_recovery_control, input logic [7:0] p2, input logic [2:0] up,
		input logic an, input logic cm, input logic exp);
		wr(`IWC_ADDR_SMR, stop_recovery_control);
		enter_sleep_i = 1'b1;
		tick(1);
		enter_sleep_i = 1'b0;
		rd(`IWC_ADDR_SMR, {1'b1, stop_recovery_control[6:0]});
		chk(sleeping_o, 1'b1);
		{analog_mode_i, serial_enable_i, serial_compare_enable_i, serial_compare_match_i} =
			{an, cm, cm, cm};
		port_two_i = p2;
		{upper_port_line3_i, upper_port_line2_i, upper_port_line1_i} = up;
		seen = 1'b0;
		sr = 1'b0;
		repeat (60) begin
			tick(1);
			seen |= wake_o;
			sr |= wake_reset_o;
		end
		chk(seen, exp);
		chk(sr, exp & stop_recovery_control[5]);
		port_two_i = 8'hff;
		{upper_port_line3_i, upper_port_line2_i, upper_port_line1_i} = 3'h7;
		{analog_mode_i, serial_enable_i, serial_compare_enable_i, serial_compare_match_i} = 4'h0;
		rst_dut();
		rd(`IWC_ADDR_SMR, `IWC_SMR_RESET);
	endtask
	task automatic test_done();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		#200000;
		failures++;
		test_done();
	end
	initial begin
		{reg_wr_i, int_enable_i, enter_sleep_i, slow, analog_mode_i, comparator_one_irq_i,
			comparator_two_irq_i, timer_in_sel_i, timer_in_edge_i, timer_zero_i, timer_one_i,
			serial_enable_i, serial_byte_done_i, serial_compare_enable_i,
			serial_compare_match_i, reg_addr_i, reg_wdata_i} = '0;
		// Pins idle high so reset leaves no false edges
		{upper_port_line3_i, upper_port_line2_i, upper_port_line1_i} = 3'h7;
		port_two_i = 8'hff;
		void'($urandom(3));
		rst_dut();
		rd(`IWC_ADDR_SMR, `IWC_SMR_RESET);
		rd(8'h00, 8'h00);
		wr(`IWC_ADDR_MASK, 8'h3f);
		for (e = 0; e < 3; e++) begin
			k = (e == 2) ? 3'h7 : 3'($urandom % 6);
			slow = e[0];
			wr(`IWC_ADDR_PRIO, {5'h0, k});
			wr(`IWC_ADDR_REQ, 8'h3f);
			int_enable_i = 1'b1;
			for (i = 0; i < 6; i++) grant(pri(k, i));
			int_enable_i = 1'b0;
			rd(`IWC_ADDR_REQ, 8'h00);
		end
		wr(`IWC_ADDR_MASK, 8'h00);
		int_enable_i = 1'b1;
		serial_enable_i = 1'b1;
		{timer_zero_i, timer_one_i, serial_byte_done_i} = 3'h7;
		tick(1);
		{timer_zero_i, timer_one_i, serial_byte_done_i} = 3'h0;
		tick(2);
		chk(int_cycle_o, 1'b0);
		rd(`IWC_ADDR_REQ, 8'h38);
		wr(`IWC_ADDR_REQ, 8'h00);
		serial_enable_i = 1'b0;
		serial_byte_done_i = 1'b1;
		tick(1);
		serial_byte_done_i = 1'b0;
		rd(`IWC_ADDR_REQ, 8'h00);
		for (e = 0; e < 4; e++) begin
			wr(`IWC_ADDR_REQ, 8'(e << 6));
			{upper_port_line3_i, upper_port_line2_i, upper_port_line1_i} = 3'h0;
			tick(6);
			rd(`IWC_ADDR_REQ, {e[1:0], 3'h0, e != 2, 1'b1, e != 1});
			wr(`IWC_ADDR_REQ, 8'(e << 6));
			{upper_port_line3_i, upper_port_line2_i, upper_port_line1_i} = 3'h7;
			tick(6);
			rd(`IWC_ADDR_REQ, {e[1:0], 3'h0, e[1], 1'b0, e[0]});
		end
		wr(`IWC_ADDR_REQ, 8'h00);
		{analog_mode_i, comparator_two_irq_i} = 2'h3;
		{upper_port_line3_i, upper_port_line2_i, upper_port_line1_i} = 3'h0;
		tick(6);
		rd(`IWC_ADDR_REQ, 8'h03);
		wr(`IWC_ADDR_REQ, 8'h00);
		{analog_mode_i, comparator_two_irq_i, timer_in_sel_i, timer_in_edge_i} = 4'h3;
		{upper_port_line3_i, upper_port_line2_i, upper_port_line1_i} = 3'h7;
		tick(1);
		timer_in_edge_i = 1'b0;
		tick(6);
		rd(`IWC_ADDR_REQ, 8'h04);
		timer_in_sel_i = 1'b0;
		int_enable_i = 1'b0;
		wk(8'h14, 8'h7f, 3'h7, 1'b0, 1'b0, 1'b1);
		wk(8'h58, 8'hf0, 3'h7, 1'b0, 1'b0, 1'b1);
		wk(8'h7c, 8'h00, 3'h7, 1'b0, 1'b0, 1'b1);
		wk(8'h08, 8'hff, 3'h6, 1'b0, 1'b0, 1'b1);
		wk(8'h08, 8'hff, 3'h6, 1'b1, 1'b0, 1'b0);
		wk(8'h00, 8'h00, 3'h0, 1'b0, 1'b0, 1'b0);
		wk(8'h14, 8'hff, 3'h7, 1'b0, 1'b1, 1'b1);
		test_done();
	end
endmodule // iwc_interrupt_wake_tb
`default_nettype wire
